// ===== core/hlie_params.svh
// Constants for the data-link event status and enable block.
// Assumes inclusion by the block, its detector and the bench, not by core/hlie_pkg.sv.
`ifndef HLIE_PARAMS_SVH
`define HLIE_PARAMS_SVH

// ==========================================
// Register offsets
`define HLIE_ADDR_W          4
`define HLIE_OFF_STATUS      4'h0
`define HLIE_OFF_ENABLE      4'h1

// ==========================================
// Field positions
`define HLIE_BIT_KIND        7
`define HLIE_BIT_TX_START    6
`define HLIE_BIT_RX_START    5
`define HLIE_BIT_TX_END      4
`define HLIE_BIT_RX_END      3
`define HLIE_BIT_CHECKSUM    2
`define HLIE_BIT_ABORT       1
`define HLIE_BIT_IDLE        0

// ==========================================
// Reset values and masks
`define HLIE_STATUS_RST      7'h00
`define HLIE_ENABLE_RST      7'h00
`define HLIE_KIND_RST        1'b0
`define HLIE_IDLE_OCTET      8'h7e
`define HLIE_ABORT_ONES      3'd7

`endif

// ===== core/hlie_pkg.sv
// Types for the data-link event status and enable block.
// Assumes the params header sits beside it.
`default_nettype none

package hlie_pkg;

  // ==========================================
  // Event strobes from the data-link controllers
  typedef struct packed {
    logic tx_start;
    logic rx_start;
    logic tx_end;
    logic rx_message_end;
    logic rx_buffer_full;
    logic checksum_bad;
    logic rx_bit_valid;
    logic rx_bit;
  } hlie_events_t;

  // ==========================================
  // Register port
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } hlie_bus_req_t;

endpackage : hlie_pkg

`default_nettype wire

// ===== core/hlie_seq_detect.sv
// Watches the incoming data-link bit stream for the flag octet and
// for a run of seven ones. Assumes one bit per valid cycle, same clock.
`default_nettype none
`include "hlie_params.svh"

module hlie_seq_detect (
  input  wire logic CLOCK,      // System clock
  input  wire logic RST,        // Synchronous reset
  input  wire logic bit_valid,  // Bit strobe
  input  wire logic bit_in,     // Received bit
  output logic      flag_hit,   // Flag octet seen
  output logic      abort_hit   // Seven ones seen
);

  logic [7:0] shift_q;
  logic [2:0] ones_q;
  logic [7:0] shift_d;

  assign shift_d = {shift_q[6:0], bit_in};

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      shift_q <= 8'h00;
    end else if (bit_valid) begin
      shift_q <= shift_d;
    end
  end

  // Saturating run counter; abort fires once per run
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ones_q <= 3'h0;
    end else if (bit_valid) begin
      if (!bit_in) begin
        ones_q <= 3'h0;
      end else if (ones_q != `HLIE_ABORT_ONES) begin
        ones_q <= ones_q + 3'h1;
      end
    end
  end

  assign flag_hit  = bit_valid && (shift_d == `HLIE_IDLE_OCTET);
  assign abort_hit = bit_valid && bit_in && (ones_q == (`HLIE_ABORT_ONES - 3'h1));

endmodule : hlie_seq_detect

`default_nettype wire

// ===== core/hlie_irq_status.sv
// Status and enable registers for the second data-link controller.
// Assumes event strobes arrive on CLOCK, one cycle long each.
//
// How it works
// - Receive-end bit 3 sets on a complete message or on a full receive buffer.
// - Checksum bit 2 sets when the last message's frame check is wrong.
// - Abort bit 1 sets when seven ones in a row arrive on the link.
// - Idle bit 0 sets when the flag octet 0x7e arrives on the link.
// - Each status bit holds its event until read, is cleared by the read, resets to 0.
// - Enable bit 6 lets transmit start raise the interrupt; reset 0.
// - Enable bit 5 lets receive start raise the interrupt; reset 0.
// - Enable bit 4 lets transmit end raise the interrupt; reset 0.
// - Enable bit 3 lets receive end raise the interrupt; reset 0.
// - Status bits 6, 5, 4 hold transmit start, receive start and transmit end.
// - Enable bits 2, 1, 0 gate checksum, abort and idle interrupts.
// - Read-only bit 7 gives the message kind: 0 bit-oriented, 1 message-oriented.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`default_nettype none
`include "hlie_params.svh"

module hlie_irq_status (
  input  wire logic                 CLOCK,     // 250 MHz clock
  input  wire logic                 RST,       // Synchronous reset, high
  input  wire hlie_pkg::hlie_bus_req_t BUS,    // Register request
  output logic [7:0]                RDATA,     // Read data, cycle after read
  input  wire hlie_pkg::hlie_events_t EVENTS,  // Controller event strobes
  input  wire logic                 MSG_KIND,  // Received message kind level
  output logic                      IRQ        // Interrupt request, high
);

  // ==========================================
  // Event gathering
  logic       flag_hit;
  logic       abort_hit;
  logic [6:0] events;
  logic [6:0] status_q;
  logic [6:0] status_d;
  logic [6:0] enable_q;
  logic       message_kind_q;
  logic [7:0] rdata_q;
  logic       status_rd;
  logic       enable_wr;

  hlie_seq_detect u_seq (
    .CLOCK     (CLOCK),
    .RST       (RST),
    .bit_valid (EVENTS.rx_bit_valid),
    .bit_in    (EVENTS.rx_bit),
    .flag_hit  (flag_hit),
    .abort_hit (abort_hit)
  );

  always_comb begin
    events                       = 7'h00;
    events[`HLIE_BIT_TX_START]   = EVENTS.tx_start;
    events[`HLIE_BIT_RX_START]   = EVENTS.rx_start;
    events[`HLIE_BIT_TX_END]     = EVENTS.tx_end;
    events[`HLIE_BIT_RX_END]     = EVENTS.rx_message_end
                                   | EVENTS.rx_buffer_full;
    events[`HLIE_BIT_CHECKSUM]   = EVENTS.checksum_bad;
    events[`HLIE_BIT_ABORT]      = abort_hit;
    events[`HLIE_BIT_IDLE]       = flag_hit;
  end

  // ==========================================
  // Register decode
  always_comb begin
    status_rd = 1'b0;
    enable_wr = 1'b0;
    if (BUS.rd && BUS.addr == `HLIE_OFF_STATUS) begin
      status_rd = 1'b1;
    end else if (BUS.wr && BUS.addr == `HLIE_OFF_ENABLE) begin
      enable_wr = 1'b1;
    end
  end

  // Read clears, but an event in the same cycle survives the clear
  assign status_d = (status_rd ? 7'h00 : status_q) | events;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      status_q <= `HLIE_STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      enable_q <= `HLIE_ENABLE_RST;
    end else if (enable_wr) begin
      enable_q <= BUS.wdata[6:0];
    end
  end

  // Kind level comes from the receive controller, same clock
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      message_kind_q <= `HLIE_KIND_RST;
    end else begin
      message_kind_q <= MSG_KIND;
    end
  end

  // Read data holds only in the cycle after the read; unmapped reads zero
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata_q <= 8'h00;
    end else if (BUS.rd && BUS.addr == `HLIE_OFF_STATUS) begin
      rdata_q <= {message_kind_q, status_q};
    end else if (BUS.rd && BUS.addr == `HLIE_OFF_ENABLE) begin
      rdata_q <= {1'b0, enable_q};
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign RDATA = rdata_q;

  // ==========================================
  // Interrupt request
  // Combinational so a read clears the request on the following edge
  assign IRQ = |(status_q & enable_q);

  // ==========================================
  // Checks
  logic [6:0] status_past_q;
  logic       was_read_q;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      was_read_q    <= 1'b0;
      status_past_q <= 7'h00;
    end else begin
      was_read_q    <= status_rd;
      status_past_q <= status_q;
    end
  end

  sequence s_read_status;
    BUS.rd && BUS.addr == `HLIE_OFF_STATUS;
  endsequence

  a_rx_end_set: assert property (@(posedge CLOCK) disable iff (RST)
    (EVENTS.rx_message_end || EVENTS.rx_buffer_full) |=> status_q[`HLIE_BIT_RX_END])
    else $error("receive end bit not set");
  a_checksum_set: assert property (@(posedge CLOCK) disable iff (RST)
    EVENTS.checksum_bad |=> status_q[`HLIE_BIT_CHECKSUM])
    else $error("checksum bit not set");
  a_abort_set: assert property (@(posedge CLOCK) disable iff (RST)
    (EVENTS.rx_bit_valid && EVENTS.rx_bit) [*7] |=> status_q[`HLIE_BIT_ABORT])
    else $error("abort bit not set after seven ones");
  a_idle_set: assert property (@(posedge CLOCK) disable iff (RST)
    flag_hit |=> status_q[`HLIE_BIT_IDLE])
    else $error("idle bit not set");
  // Events of the read's own cycle land after the clear, so only a quiet read must empty it
  a_read_clears: assert property (@(posedge CLOCK) disable iff (RST)
    s_read_status ##0 (events == 7'h00) |=> status_q == 7'h00
      && RDATA[6:0] == status_past_q)
    else $error("status not cleared by read");
  a_status_holds: assert property (@(posedge CLOCK) disable iff (RST)
    (!status_rd && events == 7'h00) |=> status_q == $past(status_q))
    else $error("status changed without cause");
  a_start_irq: assert property (@(posedge CLOCK) disable iff (RST)
    (EVENTS.tx_start && enable_q[`HLIE_BIT_TX_START] && !enable_wr) |=> IRQ)
    else $error("transmit start gave no interrupt");
  a_end_irq: assert property (@(posedge CLOCK) disable iff (RST)
    (EVENTS.tx_end && enable_q[`HLIE_BIT_TX_END] && !enable_wr) |=> IRQ)
    else $error("transmit end gave no interrupt");
  a_event_irq: assert property (@(posedge CLOCK) disable iff (RST)
    (((events & enable_q) != 7'h00) && !enable_wr) |=> IRQ)
    else $error("enabled event gave no interrupt");
  a_irq_masked: assert property (@(posedge CLOCK) disable iff (RST)
    (enable_q == 7'h00) |-> !IRQ)
    else $error("interrupt while all disabled");
  a_kind_read: assert property (@(posedge CLOCK) disable iff (RST)
    s_read_status |=> RDATA[`HLIE_BIT_KIND] == $past(message_kind_q))
    else $error("message kind misread");

endmodule : hlie_irq_status

`default_nettype wire

// ===== dv/test_hdlc_link_irq_status_enable.sv
// Self-checking bench for the data-link event status and enable block.
// Assumes core/hlie_pkg.sv and core/hlie_irq_status.sv compiled first.
`default_nettype none
`include "hlie_params.svh"

module test_hdlc_link_irq_status_enable;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    clock = 1'b0;
  logic                    rst   = 1'b1;
  hlie_pkg::hlie_bus_req_t bus   = '0;
  hlie_pkg::hlie_events_t  ev    = '0;
  logic                    kind_in = 1'b0;
  logic [7:0]              rdata;
  logic                    irq;
  int                      bad_count = 0;
  int                      comparisons = 0;
  int                      st = 0;
  int                      en = 0;
  int                      kind = 0;
  logic [7:0]              w;

  always #2 clock = ~clock;

  hlie_irq_status hlie_irq_status_i (.CLOCK(clock), .RST(rst), .BUS(bus), .RDATA(rdata),
    .EVENTS(ev), .MSG_KIND(kind_in), .IRQ(irq));

  // ==========================================
  // Shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic irq_chk;
    check("irq", {7'h00, irq}, {7'h00, 1'((st & en) != 0)});
  endtask : irq_chk

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    check("rdata", rdata, exp);
  endtask : rd

  task automatic rd_status;
    rd(`HLIE_OFF_STATUS, 8'((kind << 7) | st));
    st = 0;
    irq_chk();
  endtask : rd_status

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clock);
    bus.wr <= 1'b0;
    if (a == `HLIE_OFF_ENABLE) en = int'(d[6:0]);
    #1;
  endtask : wr

  task automatic pulse(input logic [7:0] e, input int sb);
    @(posedge clock);
    ev <= e;
    @(posedge clock);
    ev <= '0;
    #1;
    st |= 1 << sb;
    irq_chk();
  endtask : pulse

  // Bits go MSB first, one per valid cycle
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clock);
      ev <= {6'b000000, 1'b1, b[i]};
    end
    @(posedge clock);
    ev <= '0;
    repeat (2) @(posedge clock);
    #1;
  endtask : send_byte

  task automatic final_report;
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // ==========================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    final_report();
  end

  // ==========================================
  // Main sequence
  initial begin
    w = 8'($urandom(32'h9756));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd_status();
    rd(`HLIE_OFF_ENABLE, 8'h00);
    // Bit 7 of the enable never sticks
    repeat (4) begin
      w = 8'($urandom);
      wr(`HLIE_OFF_ENABLE, w);
      rd(`HLIE_OFF_ENABLE, {1'b0, w[6:0]});
    end
    wr(`HLIE_OFF_STATUS, 8'hff);
    rd(4'h2, 8'h00);
    rd_status();
    // Each of the six strobed event sources, each under a random enable mask
    for (int i = 0; i < 6; i++) begin
      wr(`HLIE_OFF_ENABLE, 8'($urandom));
      pulse(8'h80 >> i, (i < 4) ? 6 - i : 7 - i);
      rd_status();
    end
    // Flag octet, then a run of ones, then end of message
    wr(`HLIE_OFF_ENABLE, 8'h03);
    @(posedge clock);
    kind_in <= 1'b1;
    kind = 1;
    send_byte(8'h7e);
    st |= 1;
    irq_chk();
    send_byte(8'hff);
    st |= 2;
    irq_chk();
    pulse(8'h10, 3);
    rd_status();
    rd_status();
    // An event in the read's own cycle must survive the clear
    wr(`HLIE_OFF_ENABLE, 8'h40);
    pulse(8'h80, 6);
    @(posedge clock);
    bus.addr <= `HLIE_OFF_STATUS;
    bus.rd   <= 1'b1;
    ev       <= 8'h80;
    @(posedge clock);
    bus.rd <= 1'b0;
    ev     <= '0;
    #1;
    check("rdata", rdata, 8'hc0);
    irq_chk();
    wr(`HLIE_OFF_ENABLE, 8'h00);
    irq_chk();
    rd_status();
    final_report();
  end
endmodule : test_hdlc_link_irq_status_enable

`default_nettype wire
